// ===== verilog/rsar_pkg.sv
/*
 * Constants shared by both ends of the regulator register bank link:
 * command codes, field layouts, reset values, clamp limits and alert timing.
 * Assumes a single 10 MHz clock shared by host and device ends.
 */
package rsar_pkg;
    // =========================================================
    // Command codes
    localparam logic [7:0] CMD_SETPOINT = 8'h15;
    localparam logic [7:0] CMD_PHASE_CFG = 8'h39;
    localparam logic [7:0] CMD_CTRL1 = 8'h3c;
    localparam logic [7:0] CMD_TIMING_CFG = 8'h3d;
    localparam logic [7:0] CMD_CTRL3 = 8'h4c;
    localparam logic [7:0] CMD_CTRL4 = 8'h4e;
    localparam logic [7:0] CMD_SRC_THR = 8'h47;
    localparam logic [7:0] CMD_LOAD_THR = 8'h48;

    // =========================================================
    // Valid-bit masks and clamp maxima
    localparam logic [15:0] SETPOINT_MASK = 16'h7ff8;
    // 24.576 V at 12 mV per step is 2048 steps, bit 14 alone
    localparam logic [15:0] SETPOINT_MAX = 16'h4000;
    // 6.288 V at 12 mV per step is 524 steps
    localparam logic [15:0] SETPOINT_RESET = 16'h1060;
    localparam logic [15:0] SRC_THR_MASK = 16'h1f80;
    localparam logic [15:0] SRC_THR_MAX = 16'h1900;
    localparam logic [15:0] SRC_THR_RESET = 16'h0c00;
    localparam logic [15:0] LOAD_THR_MASK = 16'h3f00;
    localparam logic [15:0] LOAD_THR_MAX = 16'h3200;
    localparam logic [15:0] LOAD_THR_RESET = 16'h1000;
    localparam logic [15:0] PHASE_CFG_MASK = 16'hffe7;
    localparam logic [15:0] PHASE_CFG_RESET = 16'h0000;
    localparam logic [15:0] TIMING_CFG_MASK = 16'h07c0;
    localparam logic [15:0] TIMING_CFG_RESET = 16'h0000;

    // =========================================================
    // Field positions
    localparam int FWD_OFS_LSB = 13;
    localparam int BOOST_OFS_LSB = 10;
    localparam int REV_OFS_LSB = 7;
    localparam int HS_SHORT_LSB = 5;
    localparam int VIN_LOOP_DIS_BIT = 2;
    localparam int SRC_DIS_BIT = 1;
    localparam int LOAD_DIS_BIT = 0;
    localparam int DEBOUNCE_LSB = 9;
    localparam int HOLD_LSB = 6;

    // =========================================================
    // Alert timing, in microseconds, and cycle counts at 10 MHz
    localparam int CLK_KHZ = 10000;
    localparam int DEB_US_0 = 7;
    localparam int DEB_US_1 = 100;
    localparam int DEB_US_2 = 500;
    localparam int DEB_US_3 = 1000;
    localparam int HOLD_US_0 = 10000;
    localparam int HOLD_US_1 = 20000;
    localparam int HOLD_US_2 = 15000;
    localparam int HOLD_US_3 = 5000;
    localparam int HOLD_US_4 = 1000;
    localparam int HOLD_US_5 = 500;
    localparam int HOLD_US_6 = 100;
    localparam int CNT_W = 18;
    localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;

    // =========================================================
    // Host sequencing
    typedef enum logic [1:0] {
        RSAR_IDLE = 2'b00,
        RSAR_WAIT = 2'b01,
        RSAR_DONE = 2'b10
    } rsar_host_state_type;
endpackage : rsar_pkg

// ===== verilog/rsar_link_if.sv
/*
 * Word-level register link between host and device ends.
 * Assumes both ends share one clock; request is a one-cycle strobe.
 */
interface rsar_link_if;
    logic req;
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic throttle_alert_n;

    modport device (
        input req, wr, cmd, wdata,
        output ack, rdata, throttle_alert_n
    );
    modport host (
        output req, wr, cmd, wdata,
        input ack, rdata, throttle_alert_n
    );
endinterface : rsar_link_if

// ===== verilog/rsar_alert_timer.sv
/*
 * Debounce and minimum-hold timer for one overcurrent comparison.
 * Assumes the over-threshold level is synchronous to the clock.
 */
module rsar_alert_timer (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_over,
    input wire logic [rsar_pkg::CNT_W-1:0] i_deb_cycles,
    input wire logic [rsar_pkg::CNT_W-1:0] i_hold_cycles,
    output logic o_alert
);
    logic [rsar_pkg::CNT_W-1:0] deb_cnt;
    logic [rsar_pkg::CNT_W-1:0] hold_cnt;

    // =========================================================
    // Debounce: over-threshold must persist for the full time
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !i_over) begin
            deb_cnt <= '0;
        end else if (deb_cnt < i_deb_cycles) begin
            deb_cnt <= deb_cnt + rsar_pkg::CNT_ONE;
        end
    end

    // =========================================================
    // Latched alert with minimum hold
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_alert <= 1'b0;
            hold_cnt <= '0;
        end else if (i_over && deb_cnt >= i_deb_cycles - rsar_pkg::CNT_ONE) begin
            o_alert <= 1'b1;
            hold_cnt <= i_hold_cycles;
        end else if (hold_cnt > rsar_pkg::CNT_ONE) begin
            hold_cnt <= hold_cnt - rsar_pkg::CNT_ONE;
        end else begin
            // Zero hold still releases one cycle after the cause clears
            o_alert <= 1'b0;
            hold_cnt <= '0;
        end
    end
endmodule // rsar_alert_timer

// ===== verilog/rsar_device.sv
/*
 * Device end: setpoint, threshold and control registers of the regulator,
 * plus the active-low throttle alert.
 * Assumes overcurrent flags arrive synchronous to i_ref_clk.
 */
// Overview of operation
// - Command 0x15 writes the voltage setpoint
// - Setpoint keeps valid bits, clamps 24.576 V
// - Zero setpoint write acknowledged, value kept
// - Setpoint bits 14:3, 12 mV steps
// - Setpoint reads 6.288 V after reset
// - Host writes setpoint before enabling output
// - Command 0x47, source threshold bits 12:7
// - Source threshold masked, clamped at 6400 mA
// - Source threshold resets to 0x0c00, readable
// - Command 0x48, load threshold bits 13:8
// - Load threshold masked, clamped at 12.8 A
// - Load threshold resets to 0x1000, readable
// - Source overcurrent outside reverse mode asserts alert, debounce, hold
// - Reverse load overcurrent uses same timing
// - Host writes control words by command
// - Bits 15:13 forward buck comparator offset
// - Bits 12:10 boost comparator offset
// - Bits 9:7 reverse buck comparator offset
// - Bits 6:5 high-side short threshold
// - Bit 2 disables input voltage loop
// - Bits 1:0 enable discharge functions
// - Timing bits 10:9 select debounce
// - Timing bits 8:6 select minimum hold
module rsar_device (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    rsar_link_if.device link,
    input wire logic i_src_over,
    input wire logic i_load_over,
    input wire logic i_reverse_mode,
    output logic [15:0] o_setpoint,
    output logic [2:0] o_fwd_buck_offset,
    output logic [2:0] o_boost_offset,
    output logic [2:0] o_rev_buck_offset,
    output logic [1:0] o_hs_short_sel,
    output logic o_vin_loop_disable,
    output logic o_src_discharge_en,
    output logic o_load_discharge_en
);
    logic [15:0] forward_voltage_setpoint;
    logic [15:0] phase_tuning_config;
    logic [15:0] alert_timing_config;
    logic [15:0] source_side_alert_threshold;
    logic [15:0] load_side_alert_threshold;
    logic [15:0] sp_masked;
    logic [15:0] src_masked;
    logic [15:0] load_masked;
    logic wr_hit;
    logic [rsar_pkg::CNT_W-1:0] deb_cycles;
    logic [rsar_pkg::CNT_W-1:0] hold_cycles;
    logic src_alert;
    logic load_alert;

    assign wr_hit = link.req && link.wr;
    assign sp_masked = link.wdata & rsar_pkg::SETPOINT_MASK;
    assign src_masked = link.wdata & rsar_pkg::SRC_THR_MASK;
    assign load_masked = link.wdata & rsar_pkg::LOAD_THR_MASK;

    // =========================================================
    // Setpoint register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            forward_voltage_setpoint <= rsar_pkg::SETPOINT_RESET;
        end else if (wr_hit && link.cmd == rsar_pkg::CMD_SETPOINT
                && sp_masked != 16'h0000) begin
            if (sp_masked > rsar_pkg::SETPOINT_MAX) begin
                forward_voltage_setpoint <= rsar_pkg::SETPOINT_MAX;
            end else begin
                forward_voltage_setpoint <= sp_masked;
            end
        end
    end

    // =========================================================
    // Threshold registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            source_side_alert_threshold <= rsar_pkg::SRC_THR_RESET;
        end else if (wr_hit && link.cmd == rsar_pkg::CMD_SRC_THR) begin
            if (src_masked > rsar_pkg::SRC_THR_MAX) begin
                source_side_alert_threshold <= rsar_pkg::SRC_THR_MAX;
            end else begin
                source_side_alert_threshold <= src_masked;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            load_side_alert_threshold <= rsar_pkg::LOAD_THR_RESET;
        end else if (wr_hit && link.cmd == rsar_pkg::CMD_LOAD_THR) begin
            if (load_masked > rsar_pkg::LOAD_THR_MAX) begin
                load_side_alert_threshold <= rsar_pkg::LOAD_THR_MAX;
            end else begin
                load_side_alert_threshold <= load_masked;
            end
        end
    end

    // =========================================================
    // Control words; other control words are accepted and dropped
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            phase_tuning_config <= rsar_pkg::PHASE_CFG_RESET;
            alert_timing_config <= rsar_pkg::TIMING_CFG_RESET;
        end else if (wr_hit) begin
            if (link.cmd == rsar_pkg::CMD_PHASE_CFG) begin
                phase_tuning_config <= link.wdata & rsar_pkg::PHASE_CFG_MASK;
            end
            if (link.cmd == rsar_pkg::CMD_TIMING_CFG) begin
                alert_timing_config <= link.wdata & rsar_pkg::TIMING_CFG_MASK;
            end
        end
    end

    // =========================================================
    // Read-back and acknowledge, one cycle after the request
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            link.ack <= 1'b0;
            link.rdata <= 16'h0000;
        end else begin
            link.ack <= link.req;
            if (link.req && !link.wr) begin
                unique case (link.cmd)
                    rsar_pkg::CMD_SETPOINT: link.rdata <= forward_voltage_setpoint;
                    rsar_pkg::CMD_SRC_THR: link.rdata <= source_side_alert_threshold;
                    rsar_pkg::CMD_LOAD_THR: link.rdata <= load_side_alert_threshold;
                    rsar_pkg::CMD_PHASE_CFG: link.rdata <= phase_tuning_config;
                    rsar_pkg::CMD_TIMING_CFG: link.rdata <= alert_timing_config;
                    default: link.rdata <= 16'h0000;
                endcase
            end
        end
    end

    // =========================================================
    // Alert timing decode
    always_comb begin
        unique case (alert_timing_config[rsar_pkg::DEBOUNCE_LSB +: 2])
            2'b00: deb_cycles = rsar_pkg::CNT_W'(rsar_pkg::DEB_US_0 * rsar_pkg::CLK_KHZ / 1000);
            2'b01: deb_cycles = rsar_pkg::CNT_W'(rsar_pkg::DEB_US_1 * rsar_pkg::CLK_KHZ / 1000);
            2'b10: deb_cycles = rsar_pkg::CNT_W'(rsar_pkg::DEB_US_2 * rsar_pkg::CLK_KHZ / 1000);
            2'b11: deb_cycles = rsar_pkg::CNT_W'(rsar_pkg::DEB_US_3 * rsar_pkg::CLK_KHZ / 1000);
        endcase
        unique case (alert_timing_config[rsar_pkg::HOLD_LSB +: 3])
            3'b000: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_0 * rsar_pkg::CLK_KHZ / 1000);
            3'b001: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_1 * rsar_pkg::CLK_KHZ / 1000);
            3'b010: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_2 * rsar_pkg::CLK_KHZ / 1000);
            3'b011: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_3 * rsar_pkg::CLK_KHZ / 1000);
            3'b100: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_4 * rsar_pkg::CLK_KHZ / 1000);
            3'b101: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_5 * rsar_pkg::CLK_KHZ / 1000);
            3'b110: hold_cycles = rsar_pkg::CNT_W'(rsar_pkg::HOLD_US_6 * rsar_pkg::CLK_KHZ / 1000);
            3'b111: hold_cycles = '0;
        endcase
    end

    rsar_alert_timer u_src_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_over(i_src_over && !i_reverse_mode),
        .i_deb_cycles(deb_cycles),
        .i_hold_cycles(hold_cycles),
        .o_alert(src_alert)
    );

    rsar_alert_timer u_load_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_over(i_load_over && i_reverse_mode),
        .i_deb_cycles(deb_cycles),
        .i_hold_cycles(hold_cycles),
        .o_alert(load_alert)
    );

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            link.throttle_alert_n <= 1'b1;
        end else begin
            link.throttle_alert_n <= !(src_alert || load_alert);
        end
    end

    // =========================================================
    // Registered control outputs to the analog side
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_setpoint <= rsar_pkg::SETPOINT_RESET;
            o_fwd_buck_offset <= 3'h0;
            o_boost_offset <= 3'h0;
            o_rev_buck_offset <= 3'h0;
            o_hs_short_sel <= 2'h0;
            o_vin_loop_disable <= 1'b0;
            o_src_discharge_en <= 1'b0;
            o_load_discharge_en <= 1'b0;
        end else begin
            o_setpoint <= forward_voltage_setpoint;
            o_fwd_buck_offset <= phase_tuning_config[rsar_pkg::FWD_OFS_LSB +: 3];
            o_boost_offset <= phase_tuning_config[rsar_pkg::BOOST_OFS_LSB +: 3];
            o_rev_buck_offset <= phase_tuning_config[rsar_pkg::REV_OFS_LSB +: 3];
            o_hs_short_sel <= phase_tuning_config[rsar_pkg::HS_SHORT_LSB +: 2];
            o_vin_loop_disable <= phase_tuning_config[rsar_pkg::VIN_LOOP_DIS_BIT];
            o_src_discharge_en <= phase_tuning_config[rsar_pkg::SRC_DIS_BIT];
            o_load_discharge_en <= phase_tuning_config[rsar_pkg::LOAD_DIS_BIT];
        end
    end
endmodule // rsar_device

// ===== verilog/rsar_host.sv
/*
 * Host end: issues one write-word or read-word per user request over the link.
 * Assumes the device answers with ack one cycle after each request.
 */
module rsar_host (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    rsar_link_if.host link,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [7:0] i_cmd,
    input wire logic [15:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_throttle_alert_n
);
    rsar_pkg::rsar_host_state_type state;

    // =========================================================
    // One transaction at a time; starts while busy are ignored
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state <= rsar_pkg::RSAR_IDLE;
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.cmd <= 8'h00;
            link.wdata <= 16'h0000;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
        end else begin
            link.req <= 1'b0;
            o_done <= 1'b0;
            unique case (state)
                rsar_pkg::RSAR_IDLE: begin
                    if (i_start) begin
                        link.req <= 1'b1;
                        link.wr <= i_write;
                        link.cmd <= i_cmd;
                        link.wdata <= i_wdata;
                        o_busy <= 1'b1;
                        state <= rsar_pkg::RSAR_WAIT;
                    end
                end
                rsar_pkg::RSAR_WAIT: begin
                    if (link.ack) begin
                        if (!link.wr) begin
                            o_rdata <= link.rdata;
                        end
                        o_done <= 1'b1;
                        o_busy <= 1'b0;
                        state <= rsar_pkg::RSAR_IDLE;
                    end
                end
                default: state <= rsar_pkg::RSAR_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_throttle_alert_n <= 1'b1;
        end else begin
            o_throttle_alert_n <= link.throttle_alert_n;
        end
    end
endmodule // rsar_host

// ===== bench/rsar_link_assertions.sv
/*
 * Concurrent checks on the word link between host and device ends.
 * Assumes one clock and a synchronous active-low reset; instantiated beside the link.
 */
module rsar_link_assertions (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] cmd,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic throttle_alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    // =========================================================
    // Handshake
    sequence s_read(logic [7:0] c);
        req && !wr && cmd == c ##1 ack;
    endsequence

    property p_ack_follows_req;
        req |=> ack;
    endproperty
    a_ack_follows_req: assert property (p_ack_follows_req)
        else $error("ack missing one cycle after request");

    property p_no_stray_ack;
        !req |=> !ack;
    endproperty
    a_no_stray_ack: assert property (p_no_stray_ack)
        else $error("ack without request");

    // Read word must survive writes and idle cycles
    property p_rdata_holds;
        !(req && !wr) |=> $stable(rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read word changed without a read");

    // =========================================================
    // Register contents seen on reads
    property p_setpoint_unused;
        s_read(rsar_pkg::CMD_SETPOINT) |-> (rdata & ~rsar_pkg::SETPOINT_MASK) == 16'h0000;
    endproperty
    a_setpoint_unused: assert property (p_setpoint_unused)
        else $error("setpoint unused bits set");

    property p_setpoint_clamp;
        s_read(rsar_pkg::CMD_SETPOINT) |-> rdata <= rsar_pkg::SETPOINT_MAX;
    endproperty
    a_setpoint_clamp: assert property (p_setpoint_clamp)
        else $error("setpoint above maximum");

    property p_src_thr_range;
        s_read(rsar_pkg::CMD_SRC_THR) |->
            (rdata & ~rsar_pkg::SRC_THR_MASK) == 16'h0000 && rdata <= rsar_pkg::SRC_THR_MAX;
    endproperty
    a_src_thr_range: assert property (p_src_thr_range)
        else $error("source threshold out of range");

    property p_load_thr_range;
        s_read(rsar_pkg::CMD_LOAD_THR) |->
            (rdata & ~rsar_pkg::LOAD_THR_MASK) == 16'h0000 && rdata <= rsar_pkg::LOAD_THR_MAX;
    endproperty
    a_load_thr_range: assert property (p_load_thr_range)
        else $error("load threshold out of range");

    property p_phase_unused;
        s_read(rsar_pkg::CMD_PHASE_CFG) |-> rdata[4:3] == 2'h0;
    endproperty
    a_phase_unused: assert property (p_phase_unused)
        else $error("phase config unused bits set");

    property p_timing_unused;
        s_read(rsar_pkg::CMD_TIMING_CFG) |-> (rdata & ~rsar_pkg::TIMING_CFG_MASK) == 16'h0000;
    endproperty
    a_timing_unused: assert property (p_timing_unused)
        else $error("timing config unused bits set");
endmodule // rsar_link_assertions

// ===== bench/testbench.sv
/*
 * Self-checking bench joining host and device ends over the word link.
 * Assumes the host end answers o_done three cycles after a taken start.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    logic i_write = 1'b0;
    logic [7:0] i_cmd = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_src_over = 1'b0;
    logic i_load_over = 1'b0;
    logic i_reverse_mode = 1'b0;
    logic o_busy, o_done, o_throttle_alert_n;
    logic [15:0] o_rdata, o_setpoint;
    logic [2:0] o_fwd_buck_offset, o_boost_offset, o_rev_buck_offset;
    logic [1:0] o_hs_short_sel;
    logic o_vin_loop_disable, o_src_discharge_en, o_load_discharge_en;
    logic [15:0] cfg_view;
    int err_total = 0;
    int num_checks = 0;

    always #50 i_ref_clk = ~i_ref_clk;
    // Field outputs packed back into register layout
    assign cfg_view = {o_fwd_buck_offset, o_boost_offset, o_rev_buck_offset, o_hs_short_sel,
        2'b00, o_vin_loop_disable, o_src_discharge_en, o_load_discharge_en};

    rsar_link_if link();
    rsar_host i_rsar_host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
        .i_start(i_start), .i_write(i_write), .i_cmd(i_cmd), .i_wdata(i_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
        .o_throttle_alert_n(o_throttle_alert_n));
    rsar_device i_rsar_device (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link),
        .i_src_over(i_src_over), .i_load_over(i_load_over), .i_reverse_mode(i_reverse_mode),
        .o_setpoint(o_setpoint), .o_fwd_buck_offset(o_fwd_buck_offset),
        .o_boost_offset(o_boost_offset), .o_rev_buck_offset(o_rev_buck_offset),
        .o_hs_short_sel(o_hs_short_sel), .o_vin_loop_disable(o_vin_loop_disable),
        .o_src_discharge_en(o_src_discharge_en), .o_load_discharge_en(o_load_discharge_en));
    rsar_link_assertions i_rsar_link_assertions (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .req(link.req), .wr(link.wr), .cmd(link.cmd), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .throttle_alert_n(link.throttle_alert_n));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
            output logic [15:0] r);
        int n;
        i_start <= 1'b1;
        i_write <= w;
        i_cmd <= c;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 10) begin
            @(posedge i_ref_clk);
            n++;
            if (n == 1) begin
                chk({15'h0000, o_busy}, 16'h0001);
            end
        end
        if (n == 10) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        chk(16'(n), 16'h0003);
        chk({15'h0000, o_busy}, 16'h0000);
        r = o_rdata;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        xfer(1'b1, c, d, r);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] r;
        xfer(1'b0, c, 16'h0000, r);
        chk(r, exp);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =========================================================
    // Scenarios
    task automatic t_reset_values;
        chk(o_setpoint, 16'h1060);
        chk(cfg_view, 16'h0000);
        rd(rsar_pkg::CMD_SETPOINT, 16'h1060);
        rd(rsar_pkg::CMD_SRC_THR, 16'h0c00);
        rd(rsar_pkg::CMD_LOAD_THR, 16'h1000);
        rd(rsar_pkg::CMD_PHASE_CFG, 16'h0000);
    endtask

    task automatic t_setpoint;
        wr(rsar_pkg::CMD_SETPOINT, 16'hffff);
        rd(rsar_pkg::CMD_SETPOINT, 16'h4000);
        wr(rsar_pkg::CMD_SETPOINT, 16'h4008);
        rd(rsar_pkg::CMD_SETPOINT, 16'h4000);
        wr(rsar_pkg::CMD_SETPOINT, 16'h1234);
        rd(rsar_pkg::CMD_SETPOINT, 16'h1230);
        chk(o_setpoint, 16'h1230);
        wr(rsar_pkg::CMD_SETPOINT, 16'h8007);
        rd(rsar_pkg::CMD_SETPOINT, 16'h1230);
        wr(rsar_pkg::CMD_SETPOINT, 16'h0000);
        rd(rsar_pkg::CMD_SETPOINT, 16'h1230);
    endtask

    task automatic t_thresholds;
        wr(rsar_pkg::CMD_SRC_THR, 16'hffff);
        rd(rsar_pkg::CMD_SRC_THR, 16'h1900);
        wr(rsar_pkg::CMD_SRC_THR, 16'h0aff);
        rd(rsar_pkg::CMD_SRC_THR, 16'h0a80);
        wr(rsar_pkg::CMD_LOAD_THR, 16'h3300);
        rd(rsar_pkg::CMD_LOAD_THR, 16'h3200);
        wr(rsar_pkg::CMD_LOAD_THR, 16'hc1ff);
        rd(rsar_pkg::CMD_LOAD_THR, 16'h0100);
    endtask

    task automatic t_config;
        logic [7:0] dead[4] = '{8'h3c, 8'h4c, 8'h4e, 8'h00};
        wr(rsar_pkg::CMD_PHASE_CFG, 16'hdefd);
        rd(rsar_pkg::CMD_PHASE_CFG, 16'hdee5);
        chk(cfg_view, 16'hdee5);
        wr(rsar_pkg::CMD_PHASE_CFG, 16'h2102);
        chk(cfg_view, 16'h2102);
        // Dropped writes must read back zero and must not leak into the setpoint
        foreach (dead[k]) begin
            wr(dead[k], 16'hffff);
            rd(dead[k], 16'h0000);
        end
        rd(rsar_pkg::CMD_SETPOINT, 16'h1230);
        wr(rsar_pkg::CMD_TIMING_CFG, 16'hffff);
        rd(rsar_pkg::CMD_TIMING_CFG, 16'h07c0);
    endtask

    task automatic alert_case(input logic rev, input logic s, input logic l,
            input logic [1:0] deb, input int deb_cyc, input logic [2:0] hold, input int hold_cyc,
            input logic fire);
        wr(rsar_pkg::CMD_TIMING_CFG, {5'h00, deb, hold, 6'h00});
        i_reverse_mode <= rev;
        @(posedge i_ref_clk);
        i_src_over <= s;
        i_load_over <= l;
        repeat (deb_cyc - 5) @(posedge i_ref_clk);
        chk({15'h0000, link.throttle_alert_n}, 16'h0001);
        repeat (10) @(posedge i_ref_clk);
        chk({15'h0000, link.throttle_alert_n}, {15'h0000, !fire});
        chk({15'h0000, o_throttle_alert_n}, {15'h0000, !fire});
        i_src_over <= 1'b0;
        i_load_over <= 1'b0;
        if (fire && hold_cyc > 0) begin
            repeat (hold_cyc * 9 / 10) @(posedge i_ref_clk);
            chk({15'h0000, link.throttle_alert_n}, 16'h0000);
        end
        repeat (hold_cyc / 5 + 10) @(posedge i_ref_clk);
        chk({15'h0000, link.throttle_alert_n}, 16'h0001);
    endtask

    // =========================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset_values();
        t_setpoint();
        t_thresholds();
        t_config();
        alert_case(1'b0, 1'b1, 1'b0, 2'b00, 70, 3'b111, 0, 1'b1);
        alert_case(1'b0, 1'b0, 1'b1, 2'b00, 70, 3'b111, 0, 1'b0);
        alert_case(1'b1, 1'b0, 1'b1, 2'b01, 1000, 3'b110, 1000, 1'b1);
        alert_case(1'b1, 1'b1, 1'b0, 2'b00, 70, 3'b111, 0, 1'b0);
        alert_case(1'b0, 1'b1, 1'b0, 2'b10, 5000, 3'b101, 5000, 1'b1);
        alert_case(1'b1, 1'b0, 1'b1, 2'b11, 10000, 3'b100, 10000, 1'b1);
        tally_and_finish();
    end

    // Whole run needs about thirty-four thousand cycles
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        err_total++;
        tally_and_finish();
    end
endmodule // testbench
